// File: shp_host_port.sv
// Purpose: Device side of a 16-bit strobe host port with hold-off output.
// Assumes: Host pins are synchronous to bus_clk_i; straps are static.
// Notes:   Storage and refresh arbitration run on clk_i; AHB-Lite status.
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module shp_host_port (
  input  wire logic        clk_i,                      // Core clock.
  input  wire logic        resetn_i,                   // Reset, active low.
  input  wire logic        bus_clk_i,                  // Host port clock.
  input  wire logic        cs_n_i,                     // Device select.
  input  wire logic [16:0] host_address_in_i,          // Host address.
  input  wire logic [15:0] host_data_bus_i,            // Data pins in.
  output logic      [15:0] host_data_bus_o,            // Data pins out.
  output logic             host_data_bus_oe_n_o,       // Drive, active low.
  input  wire logic        low_byte_write_strobe_n_i,  // Low byte write.
  input  wire logic        high_byte_write_strobe_n_i, // High byte write.
  input  wire logic        low_byte_read_strobe_n_i,   // Low byte read.
  input  wire logic        high_byte_read_strobe_n_i,  // High byte read.
  input  wire logic        bus_start_strap_n_i,        // Bus-start strap.
  input  wire logic        mode_strap_0_i,             // Mode strap 0.
  input  wire logic        mode_strap_1_i,             // Mode strap 1.
  input  wire logic        mode_strap_2_i,             // Mode strap 2.
  input  wire logic        endian_strap_i,             // Byte order strap.
  output logic             hold_off_n_o,               // Wait, active low.
  input  wire logic        hsel_i,                     // AHB select.
  input  wire logic [31:0] haddr_i,                    // AHB address.
  input  wire logic [1:0]  htrans_i,                   // AHB transfer type.
  input  wire logic        hwrite_i,                   // AHB write.
  input  wire logic [2:0]  hsize_i,                    // AHB size.
  input  wire logic [31:0] hwdata_i,                   // AHB write data.
  input  wire logic        hready_i,                   // AHB ready in.
  output logic             hreadyout_o,                // AHB ready out.
  output logic             hresp_o,                    // AHB response.
  output logic      [31:0] hrdata_o                    // AHB read data.
);

  // Swaps the two byte lanes of a word for big-endian operation.
  function automatic logic [15:0] swap16(input logic [15:0] w,
                                         input logic        big);
    swap16 = big ? {w[7:0], w[15:8]} : w;
  endfunction : swap16

  // ---------------------------------------------------------------- core
  // Strap capture.
  logic [shp_pkg::STRAP_W-1:0] strap_sync;
  shp_pkg::shp_strap_t         cfg_q;
  logic                        cfg_valid_q;
  logic [2:0]                  settle_q;
  logic                        mode_ok;

  shp_sync3 #(.W(shp_pkg::STRAP_W)) u_strap_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      ({endian_strap_i, bus_start_strap_n_i, mode_strap_2_i,
                mode_strap_1_i, mode_strap_0_i}),
    .q_o      (strap_sync)
  );

  // Straps are latched once, after the synchroniser has settled.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      settle_q    <= '0;
      cfg_q       <= '0;
      cfg_valid_q <= 1'b0;
    end else if (!cfg_valid_q) begin
      if (settle_q == shp_pkg::STRAP_SETTLE) begin
        cfg_q       <= strap_sync;
        cfg_valid_q <= 1'b1;
      end else begin
        settle_q <= settle_q + 3'h1;
      end
    end
  end

  // Strobe mode needs the mode straps high and bus-start low.
  assign mode_ok = cfg_valid_q && (cfg_q.mode == shp_pkg::MODE_STROBE) &&
                   (cfg_q.bus_start_n == shp_pkg::BUS_START_LEVEL);

  // Request handshake from the link domain.
  shp_pkg::shp_req_t req_q;
  logic              req_tgl_q;
  logic              core_req_tgl;
  logic              ack_tgl_q;
  logic [15:0]       rd_q;
  logic [31:0]       count_q;
  logic [31:0]       ctrl_q;

  shp_sync3 #(.W(1)) u_req_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .d_i      (req_tgl_q),
    .q_o      (core_req_tgl)
  );

  // Refresh scheduling and arbitration against the host.
  logic [7:0] refr_cnt_q;
  logic [2:0] refr_left_q;
  logic       refr_busy;
  logic       refr_due;
  logic       pending;
  logic       grant;
  logic       to_regs;
  logic [shp_pkg::MEM_IDX_W-1:0] mem_idx;
  logic [shp_pkg::REG_IDX_W-1:0] reg_idx;

  assign pending   = core_req_tgl != ack_tgl_q;
  assign refr_busy = refr_left_q != 3'h0;
  assign refr_due  = ctrl_q[shp_pkg::CTRL_REFR_EN] &&
                     (refr_cnt_q == ctrl_q[shp_pkg::CTRL_PER_LSB +:
                                           shp_pkg::CTRL_PER_W]);
  assign grant     = pending && !refr_busy && !refr_due;
  assign to_regs   = req_q.addr[shp_pkg::ADDR_W-1:shp_pkg::REG_TAG_LSB]
                     == shp_pkg::REG_TAG;
  assign mem_idx   = req_q.addr[shp_pkg::WORD_LSB +: shp_pkg::MEM_IDX_W];
  assign reg_idx   = req_q.addr[shp_pkg::WORD_LSB +: shp_pkg::REG_IDX_W];

  // Refresh owns storage for a fixed burst each period.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      refr_cnt_q  <= '0;
      refr_left_q <= '0;
    end else if (refr_due) begin
      refr_cnt_q  <= '0;
      refr_left_q <= shp_pkg::REFRESH_LEN;
    end else begin
      refr_cnt_q  <= refr_cnt_q + 8'h01;
      refr_left_q <= refr_busy ? refr_left_q - 3'h1 : refr_left_q;
    end
  end

  // Display memory and internal registers, one byte lane per loop pass.
  logic [shp_pkg::LANES-1:0][shp_pkg::BYTE_W-1:0] rd_lane;

  for (genvar b = 0; b < shp_pkg::LANES; b++) begin : g_lane
    logic [shp_pkg::BYTE_W-1:0] mem_q  [shp_pkg::MEM_WORDS];
    logic [shp_pkg::BYTE_W-1:0] regs_q [shp_pkg::REG_WORDS];
    logic [shp_pkg::BYTE_W-1:0] wbyte;

    // Lane byte in and out; each lane owns its storage alone.
    assign wbyte      = req_q.wdata[b*shp_pkg::BYTE_W +: shp_pkg::BYTE_W];
    assign rd_lane[b] = to_regs ? regs_q[reg_idx] : mem_q[mem_idx];

    // Separate arrays per lane keep a single writer for every word.
    always_ff @(posedge clk_i) begin
      if (grant && req_q.write && req_q.be[b]) begin
        if (to_regs) begin
          regs_q[reg_idx] <= wbyte;
        end else begin
          mem_q[mem_idx] <= wbyte;
        end
      end
    end
  end

  // Granted access returns data and acknowledges by toggle.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_q      <= '0;
      ack_tgl_q <= 1'b0;
      count_q   <= '0;
    end else if (grant) begin
      rd_q      <= rd_lane;
      ack_tgl_q <= ~ack_tgl_q;
      count_q   <= count_q + 32'h1;
    end
  end

  // ------------------------------------------------------------- AHB-Lite
  logic                          ahb_go;
  logic                          wr_pend_q;
  logic [shp_pkg::AHB_OFF_W-1:0] wr_off_q;
  logic [31:0]                   status;
  logic [31:0]                   rd_mux;
  logic [shp_pkg::AHB_OFF_W-1:0] ahb_off;

  // Register select and read multiplexer for the address phase.
  assign ahb_go  = hsel_i && hready_i && htrans_i[shp_pkg::HTRANS_ACT_BIT];
  assign ahb_off = haddr_i[shp_pkg::AHB_OFF_W-1:0];
  assign status  = {23'h0, refr_busy, pending, mode_ok, cfg_valid_q,
                    cfg_q};
  assign rd_mux  = (ahb_off == shp_pkg::OFF_CTRL)   ? ctrl_q  :
                   (ahb_off == shp_pkg::OFF_STATUS) ? status  :
                   (ahb_off == shp_pkg::OFF_COUNT)  ? count_q :
                   32'h0;

  // Address phase latches writes and samples read data.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_pend_q <= 1'b0;
      wr_off_q  <= '0;
      hrdata_o  <= '0;
    end else begin
      wr_pend_q <= ahb_go && hwrite_i;
      wr_off_q  <= ahb_off;
      if (ahb_go && !hwrite_i) begin
        hrdata_o <= rd_mux;
      end
    end
  end

  // Data phase stores the control word; zero wait, always OKAY.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q      <= shp_pkg::CTRL_RESET;
      hreadyout_o <= 1'b1;
      hresp_o     <= shp_pkg::HRESP_OKAY;
    end else if (wr_pend_q && wr_off_q == shp_pkg::OFF_CTRL) begin
      ctrl_q <= hwdata_i & shp_pkg::CTRL_MASK;
    end
  end

  // ---------------------------------------------------------------- link
  // Configuration and acknowledge cross into the bus clock domain.
  logic [1:0] lk_cfg;
  logic       lk_ack_tgl;
  logic       lk_mode_ok;
  logic       lk_big;

  shp_sync3 #(.W(2)) u_cfg_sync (
    .clk_i    (bus_clk_i),
    .resetn_i (resetn_i),
    .d_i      ({mode_ok, cfg_q.endian}),
    .q_o      (lk_cfg)
  );

  shp_sync3 #(.W(1)) u_ack_sync (
    .clk_i    (bus_clk_i),
    .resetn_i (resetn_i),
    .d_i      (ack_tgl_q),
    .q_o      (lk_ack_tgl)
  );

  assign lk_mode_ok = lk_cfg[1];
  assign lk_big     = lk_cfg[0];

  // Pin decode; bus-start plays no part once the mode is chosen.
  logic [1:0]        wr_lanes;
  logic [1:0]        rd_lanes;
  logic              access;
  logic              strobes_off;
  shp_pkg::shp_req_t new_req;

  assign wr_lanes = lk_big ? {~low_byte_write_strobe_n_i,
                              ~high_byte_write_strobe_n_i}
                           : {~high_byte_write_strobe_n_i,
                              ~low_byte_write_strobe_n_i};
  assign rd_lanes = {~high_byte_read_strobe_n_i,
                     ~low_byte_read_strobe_n_i};
  assign strobes_off = (wr_lanes == 2'h0) && (rd_lanes == 2'h0);
  assign access   = !cs_n_i && !strobes_off && lk_mode_ok;
  assign new_req  = '{write: wr_lanes != 2'h0,
                      be:    wr_lanes,
                      addr:  host_address_in_i,
                      wdata: swap16(host_data_bus_i, lk_big)};

  // Link sequencer: capture, hold off, complete, release bus.
  shp_pkg::shp_link_state_t lk_state_q;
  shp_pkg::shp_link_state_t lk_state_d;
  shp_pkg::shp_req_t        req_d;
  logic                     req_tgl_d;
  logic                     hold_d;
  logic [15:0]              dout_d;
  logic                     doe_n_d;

  always_comb begin
    lk_state_d = lk_state_q;
    req_d      = req_q;
    req_tgl_d  = req_tgl_q;
    hold_d     = hold_off_n_o;
    dout_d     = host_data_bus_o;
    doe_n_d    = host_data_bus_oe_n_o;
    unique case (lk_state_q)
      shp_pkg::LK_IDLE: begin
        if (access) begin
          req_d      = new_req;
          req_tgl_d  = ~req_tgl_q;
          hold_d     = 1'b0;
          lk_state_d = shp_pkg::LK_WAIT;
        end
      end
      shp_pkg::LK_WAIT: begin
        if (lk_ack_tgl == req_tgl_q) begin
          hold_d     = 1'b1;
          lk_state_d = shp_pkg::LK_DONE;
          if (!req_q.write) begin
            dout_d  = swap16(rd_q, lk_big);
            doe_n_d = 1'b0;
          end
        end
      end
      shp_pkg::LK_DONE: begin
        if (cs_n_i || strobes_off) begin
          doe_n_d    = 1'b1;
          lk_state_d = shp_pkg::LK_IDLE;
        end
      end
    endcase
  end

  // Link registers, on the host bus clock only.
  always_ff @(posedge bus_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lk_state_q           <= shp_pkg::LK_IDLE;
      req_q                <= '0;
      req_tgl_q            <= 1'b0;
      hold_off_n_o         <= 1'b1;
      host_data_bus_o      <= '0;
      host_data_bus_oe_n_o <= 1'b1;
    end else begin
      lk_state_q           <= lk_state_d;
      req_q                <= req_d;
      req_tgl_q            <= req_tgl_d;
      hold_off_n_o         <= hold_d;
      host_data_bus_o      <= dout_d;
      host_data_bus_oe_n_o <= doe_n_d;
    end
  end

endmodule : shp_host_port

// File: shp_pkg.sv
// Purpose: Shared constants and types for the strobe host bus port.
// Assumes: Host port pins are synchronous to the host bus clock.
// Notes:   Every offset, control field position and storage count lives here; the status bit layout is packed in the port.
package shp_pkg;

  // Host port widths.
  localparam int ADDR_W  = 17;
  localparam int DATA_W  = 16;
  localparam int BYTE_W  = 8;
  localparam int LANES   = 2;

  // Strap decode for the simple strobe mode.
  localparam logic [2:0] MODE_STROBE     = 3'h7;
  localparam logic       BUS_START_LEVEL = 1'h0;
  localparam int         STRAP_W         = 5;
  localparam logic [2:0] STRAP_SETTLE    = 3'h4;

  // Internal storage map seen from the host address.
  localparam int          MEM_IDX_W   = 8;
  localparam int          MEM_WORDS   = 256;
  localparam int          REG_IDX_W   = 4;
  localparam int          REG_WORDS   = 16;
  localparam int          WORD_LSB    = 1;
  localparam int          REG_TAG_LSB = 5;
  localparam logic [11:0] REG_TAG     = 12'hfff;

  // Display refresh contention model.
  localparam logic [2:0] REFRESH_LEN = 3'h4;

  // Register bus map, byte addresses.
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_COUNT  = 8'h08;
  localparam int         AHB_OFF_W  = 8;

  // Control register fields.
  localparam int          CTRL_REFR_EN  = 0;
  localparam int          CTRL_PER_LSB  = 8;
  localparam int          CTRL_PER_W    = 8;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_1000;
  localparam logic [31:0] CTRL_MASK     = 32'h0000_ff01;

  // Bus protocol codes.
  localparam int   HTRANS_ACT_BIT = 1;
  localparam logic HRESP_OKAY     = 1'h0;

  // Strap values as captured at reset release.
  typedef struct packed {
    logic       endian;
    logic       bus_start_n;
    logic [2:0] mode;
  } shp_strap_t;

  // One host access handed from the link domain to the core domain.
  typedef struct packed {
    logic                write;
    logic [LANES-1:0]    be;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } shp_req_t;

  // Link side sequencing.
  typedef enum logic [1:0] {
    LK_IDLE,
    LK_WAIT,
    LK_DONE
  } shp_link_state_t;

endpackage : shp_pkg

// File: shp_sync3.sv
// Purpose: Three flip-flop synchroniser with agreement filter.
// Assumes: The input is a level or toggle from another clock domain.
// Notes:   The output follows only once the second and third stages agree.
`timescale 1ns/1ps
module shp_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,     // Destination clock.
  input  wire logic         resetn_i,  // Asynchronous reset, active low.
  input  wire logic [W-1:0] d_i,       // Level from the foreign domain.
  output logic      [W-1:0] q_o        // Filtered level in this domain.
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_d;

  // Bits move only where the two later stages agree.
  assign q_d = (s2_q & s3_q) | (q_o & (s2_q ^ s3_q));

  // Shift chain; the first stage feeds only the second.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q_o  <= '0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_o  <= q_d;
    end
  end

endmodule : shp_sync3

// File: shp_host_port_chk.sv
// Purpose: Concurrent checks on the host pins and the register bus.
// Assumes: Host inputs change only just after a bus clock edge.
// Notes:   Attached to every instance of the port by the bind below.
`timescale 1ns/1ps
module shp_host_port_chk (
  input wire logic clk_i,                      // Core clock.
  input wire logic resetn_i,                   // Reset, active low.
  input wire logic bus_clk_i,                  // Host port clock.
  input wire logic cs_n_i,                     // Device select.
  input wire logic low_byte_write_strobe_n_i,  // Low byte write.
  input wire logic high_byte_write_strobe_n_i, // High byte write.
  input wire logic low_byte_read_strobe_n_i,   // Low byte read.
  input wire logic high_byte_read_strobe_n_i,  // High byte read.
  input wire logic hold_off_n_o,               // Wait, active low.
  input wire logic host_data_bus_oe_n_o,       // Data drive, active low.
  input wire logic hreadyout_o,                // Bus ready.
  input wire logic hresp_o                     // Bus response.
);
  // A selected host holding any read or write strobe low.
  wire any_rd = !(low_byte_read_strobe_n_i && high_byte_read_strobe_n_i);
  wire any_wr = !(low_byte_write_strobe_n_i && high_byte_write_strobe_n_i);
  wire req    = !cs_n_i && (any_rd || any_wr);

  // The steps of one access: hold-off taken, then released.
  sequence s_wait;
    $fell(hold_off_n_o);
  endsequence
  sequence s_done;
    $rose(hold_off_n_o) && !cs_n_i;
  endsequence

  // Hold-off only answers a strobed access and is never a glitch.
  a_holdoff_cause: assert property (@(posedge bus_clk_i) disable iff (!resetn_i) s_wait |-> $past(req)) else $error("hold-off without access");
  a_holdoff_min: assert property (@(posedge bus_clk_i) disable iff (!resetn_i) s_wait |=> !hold_off_n_o) else $error("hold-off too short");
  a_holdoff_bound: assert property (@(posedge bus_clk_i) disable iff (!resetn_i) s_wait |-> ##[1:300] hold_off_n_o) else $error("hold-off never ends");
  // Release drives read data at once and gives one acknowledge only.
  a_read_drive: assert property (@(posedge bus_clk_i) disable iff (!resetn_i) s_done ##0 any_rd |-> !host_data_bus_oe_n_o) else $error("read data not driven");
  a_single_ack: assert property (@(posedge bus_clk_i) disable iff (!resetn_i) s_done |=> hold_off_n_o) else $error("second hold-off");
  // Pins stay quiet when the device is not read or selected.
  a_idle_quiet: assert property (@(posedge bus_clk_i) disable iff (!resetn_i) $past(cs_n_i) |-> hold_off_n_o) else $error("hold-off while idle");
  a_write_quiet: assert property (@(posedge bus_clk_i) disable iff (!resetn_i) !$past(any_rd) |-> host_data_bus_oe_n_o) else $error("data driven off read");
  a_ahb_okay: assert property (@(posedge clk_i) disable iff (!resetn_i) hreadyout_o && !hresp_o) else $error("bus not ready or error");
endmodule : shp_host_port_chk

bind shp_host_port shp_host_port_chk u_chk (.clk_i, .resetn_i, .bus_clk_i,
  .cs_n_i, .low_byte_write_strobe_n_i, .high_byte_write_strobe_n_i,
  .low_byte_read_strobe_n_i, .high_byte_read_strobe_n_i, .hold_off_n_o,
  .host_data_bus_oe_n_o, .hreadyout_o, .hresp_o);

// File: shp_host_model.sv
// Purpose: Host processor bus controller with its acknowledge glue.
// Assumes: The bus clock runs free, as a host system clock does.
// Notes:   Slow hosts are modelled by idle clocks between accesses.
`timescale 1ns/1ps
module shp_host_model (
  input  wire logic        bus_clk_i,    // Host bus clock.
  input  wire logic        hold_off_n_i, // Device wait output.
  input  wire logic [15:0] data_i,       // Resolved data pins.
  output logic             cs_n_o,       // Decoded select.
  output logic      [16:0] addr_o,       // Address lines.
  output logic      [15:0] data_o,       // Host data drive.
  output logic      [1:0]  wr_n_o,       // Write strobes, high lane in 1.
  output logic      [1:0]  rd_n_o        // Read strobes, high lane in 1.
);
  // Inverter enabled by select; a pull-up holds the line otherwise.
  tri1 ack_n;
  assign ack_n = cs_n_o ? 1'bz : ~hold_off_n_i;

  // Idle bus at time zero.
  initial begin
    cs_n_o = 1'b1;
    addr_o = '0;
    data_o = '0;
    wr_n_o = 2'h3;
    rd_n_o = 2'h3;
  end

  // One access: select and strobes held until acknowledge or lim clocks, then dropped.
  task automatic access(input logic w, input logic [1:0] be,
                        input logic [16:0] a, input logic [15:0] d,
                        input int lim, output logic [15:0] q,
                        output bit ok);
    bit seen;
    seen = 1'b0;
    ok = 1'b0;
    @(posedge bus_clk_i);
    cs_n_o <= 1'b0;
    addr_o <= a;
    data_o <= d;
    wr_n_o <= w ? ~be : 2'h3;
    rd_n_o <= w ? 2'h3 : ~be;
    for (int n = 0; n < lim && !ok; n++) begin
      @(posedge bus_clk_i);
      if (hold_off_n_i === 1'b0) seen = 1'b1;
      else if (seen && ack_n === 1'b0) ok = 1'b1;
    end
    q = data_i;
    cs_n_o <= 1'b1;
    wr_n_o <= 2'h3;
    rd_n_o <= 2'h3;
    addr_o <= ~a;
    data_o <= ~d;
    @(posedge bus_clk_i);
  endtask : access
endmodule : shp_host_model

// File: shp_host_port_tb.sv
// Purpose: Self-checking bench for the strobe host port.
// Assumes: Zero-wait register bus; host model on the bus clock.
// Notes:   Straps are changed only around resets, except one check.
`timescale 1ns/1ps
module shp_host_port_tb;
  typedef struct packed {
    logic [16:0] a;
    logic [1:0]  be;
    logic [15:0] d;
    logic [15:0] e;
  } shp_row_t;
  logic        clk_i, bus_clk_i, resetn_i, hsel_i, hwrite_i, bs_n, endian;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i, mode;
  logic [31:0] haddr_i, hwdata_i, q32;
  logic [15:0] q16;
  wire  [15:0] host_d, dev_d, pins;
  wire  [16:0] addr;
  wire  [1:0]  wr_n, rd_n;
  wire  [31:0] hrdata_o;
  wire         cs_n, oe_n, hold_n, hreadyout_o, hresp_o;
  int          fail_count, n_compared, n_done;
  bit          ok;
  shp_row_t    rows [5] = '{'{17'h00010, 2'h3, 16'h1234, 16'h1234},
    '{17'h00010, 2'h1, 16'hffcd, 16'h12cd}, '{17'h00010, 2'h2,
    16'h5aff, 16'h5acd}, '{17'h1ffe0, 2'h3, 16'hbeef, 16'hbeef},
    '{17'h1fffe, 2'h3, 16'h0f0f, 16'h0f0f}};

  // Data pins: the device wins while it drives.
  assign pins = !oe_n ? dev_d : host_d;

  shp_host_model u_host (.bus_clk_i(bus_clk_i), .hold_off_n_i(hold_n),
    .data_i(pins), .cs_n_o(cs_n), .addr_o(addr), .data_o(host_d),
    .wr_n_o(wr_n), .rd_n_o(rd_n));
  shp_host_port u_shp_host_port (.clk_i(clk_i), .resetn_i(resetn_i),
    .bus_clk_i(bus_clk_i), .cs_n_i(cs_n), .host_address_in_i(addr),
    .host_data_bus_i(pins), .host_data_bus_o(dev_d),
    .host_data_bus_oe_n_o(oe_n), .low_byte_write_strobe_n_i(wr_n[0]),
    .high_byte_write_strobe_n_i(wr_n[1]),
    .low_byte_read_strobe_n_i(rd_n[0]), .high_byte_read_strobe_n_i(rd_n[1]),
    .bus_start_strap_n_i(bs_n), .mode_strap_0_i(mode[0]),
    .mode_strap_1_i(mode[1]), .mode_strap_2_i(mode[2]),
    .endian_strap_i(endian), .hold_off_n_o(hold_n), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o));

  // Core clock at 10 ns; host clock at 32 ns with its own phase.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    bus_clk_i = 1'b0;
    #3;
    forever #16 bus_clk_i = ~bus_clk_i;
  end

  // Counts and reports one comparison.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  // Waits a bounded time for the bus to be ready.
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 50);
    if (hreadyout_o !== 1'b1) begin
      fail_count++;
      results();
    end
  endtask : rdy

  // One single word transfer on the register bus.
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= {24'h0, a};
    rdy();
    htrans_i <= 2'h0;
    hsel_i <= 1'b0;
    hwdata_i <= d;
    rdy();
    q = hrdata_o;
  endtask : ahb

  // One host access that must complete.
  task automatic hacc(input logic w, input logic [1:0] be,
                      input logic [16:0] a, input logic [15:0] d);
    u_host.access(w, be, a, d, 400, q16, ok);
    n_done++;
    if (!ok) begin
      fail_count++;
      results();
    end
  endtask : hacc

  // Reset with the given straps, then let the capture settle.
  task automatic rst(input logic [2:0] m, input logic e);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    mode <= m;
    endian <= e;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (20) @(posedge bus_clk_i);
  endtask : rst

  // Safety net against a hang.
  initial begin
    #1000000;
    fail_count++;
    results();
  end

  // Main sequence.
  initial begin
    {resetn_i, hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
    {mode, bs_n, endian, hsize_i} = {3'h7, 1'h0, 1'h0, 3'h2};
    rst(3'h7, 1'b0);
    ahb(1'b0, 8'h00, 32'h0, q32);
    check(q32, 32'h0000_1000);
    ahb(1'b0, 8'h04, 32'h0, q32);
    check(q32 & 32'h7f, 32'h67);
    foreach (rows[i]) begin
      hacc(1'b1, rows[i].be, rows[i].a, rows[i].d);
      hacc(1'b0, 2'h3, rows[i].a, 16'h0);
      check({16'h0, q16}, {16'h0, rows[i].e});
    end
    hacc(1'b0, 2'h1, 17'h00010, 16'h0);
    check({16'h0, q16}, 32'h5acd);
    ahb(1'b1, 8'h08, 32'hffff_ffff, q32);
    ahb(1'b0, 8'h08, 32'h0, q32);
    check(q32, n_done);
    ahb(1'b1, 8'h0c, 32'hffff_ffff, q32);
    ahb(1'b0, 8'h0c, 32'h0, q32);
    check(q32, 32'h0);
    ahb(1'b1, 8'h00, 32'hffff_ffff, q32);
    ahb(1'b0, 8'h00, 32'h0, q32);
    check(q32, 32'h0000_ff01);
    ahb(1'b1, 8'h00, 32'h0000_0801, q32);
    hacc(1'b1, 2'h3, 17'h00020, 16'ha5c3);
    hacc(1'b0, 2'h3, 17'h00020, 16'h0);
    check({16'h0, q16}, 32'ha5c3);
    mode <= 3'h6;
    endian <= 1'b1;
    repeat (10) @(posedge clk_i);
    ahb(1'b0, 8'h04, 32'h0, q32);
    check(q32 & 32'h7f, 32'h67);
    rst(3'h6, 1'b0);
    u_host.access(1'b1, 2'h3, 17'h00010, 16'h1111, 40, q16, ok);
    check({31'h0, ok}, 32'h0);
    ahb(1'b0, 8'h04, 32'h0, q32);
    check(q32 & 32'h7f, 32'h26);
    rst(3'h7, 1'b1);
    ahb(1'b0, 8'h04, 32'h0, q32);
    check(q32 & 32'h7f, 32'h77);
    hacc(1'b1, 2'h3, 17'h00040, 16'h1234);
    hacc(1'b1, 2'h1, 17'h00040, 16'hffcd);
    hacc(1'b0, 2'h3, 17'h00040, 16'h0);
    check({16'h0, q16}, 32'h12cd);
    results();
  end
endmodule : shp_host_port_tb
